/* File: rtl/serial_port_pkg.sv */
package serial_port_pkg;
  localparam logic [2:0] CLK_EXTERNAL = 3'h7; // external clock code
  localparam logic [2:0] CLK_RESERVED = 3'h6; // reserved rate code
  localparam logic [2:0] MODE_TX8 = 3'h0; // 8-bit transmit
  localparam logic [2:0] MODE_TX4 = 3'h2; // 4-bit transmit
  localparam logic [2:0] MODE_TXRX8 = 3'h4; // 8-bit transmit-receive
  localparam logic [2:0] MODE_RX8 = 3'h5; // 8-bit receive
  localparam logic [2:0] MODE_RX4 = 3'h6; // 4-bit receive
  localparam int WORDS = 8; // buffer depth
  localparam logic [7:0] FILLER_WORD = 8'hff; // filler data bits
  localparam logic [7:0] WORD_RESET = 8'h00; // buffer reset value
  localparam logic [12:0] HALF_SLOW = 13'h0fff; // half period, code 000
  localparam logic [12:0] HALF_LOW_RATE = 13'h000f; // half period, low-rate clock
  localparam logic [12:0] HALF_R1 = 13'h007f; // half period, code 001
  localparam logic [12:0] HALF_R2 = 13'h003f; // half period, code 010
  localparam logic [12:0] HALF_R3 = 13'h001f; // half period, code 011
  localparam logic [12:0] HALF_R4 = 13'h000f; // half period, code 100
  localparam logic [12:0] HALF_R5 = 13'h0007; // half period, code 101
  typedef struct packed {
    logic run_request; // start / keep running
    logic abort_request; // abort pulse
    logic [2:0] transfer_mode_select; // mode code
    logic [2:0] clock_source_select; // rate or external
    logic [2:0] word_count_select; // words minus one
    logic low_rate_divider_select; // code 000 uses low clock
  } ctrl_t;
  typedef struct packed {
    logic wr; // buffer write strobe
    logic rd; // buffer read strobe
    logic [2:0] idx; // buffer entry
    logic [7:0] wdata; // write data
  } buf_access_t;
endpackage

/* File: rtl/buffered_clocked_serial_port.sv */
module buffered_clocked_serial_port (
  input wire logic mclk, // system clock
  input wire logic resetn, // async reset, active low
  input wire serial_port_pkg::ctrl_t ctrl, // control fields
  input wire serial_port_pkg::buf_access_t acc, // software buffer access
  output logic [7:0] rdata, // buffer read data
  output logic transfer_active_flag, // transfer in progress
  output logic shift_active, // bit shifting in progress
  output logic serial_done_irq, // one-cycle done pulse
  input wire logic serial_clock_in, // clock pin input
  output logic serial_clock_out, // clock pin output
  output logic serial_clock_oe, // clock pin drive enable
  output logic serial_out_pin, // transmit data
  input wire logic serial_in_pin // receive data
);
  import serial_port_pkg::*;
  // overview: a burst of one to eight words leaves or enters the
  // buffer, lowest entry first, one bit per serial clock period
  // the serial clock is either made here from the system clock or
  // taken from the pin through a synchroniser
  // software talks to the buffer through one-cycle strobes; the
  // sequencer watches those strobes to release its waits
  // the control fields are levels and are sampled every cycle
  // the done pulse marks the end of every burst that reaches its last programmed word, except one dropped on an external receive overrun
  // a stop request lets the word in flight finish cleanly
  // an abort drops everything in the very next cycle
  // reserved rate and mode codes simply never start

  // idle: parked, clock high, shift register preloaded
  // shift: bits moving on the chosen clock
  // wait: clock held high until software catches up
  // last: one filler word in external transmit
  typedef enum {ST_IDLE, ST_SHIFT, ST_WAIT, ST_LAST} state_t;
  state_t state_reg;
  // datapath registers: buffer, shift register and counters
  // the buffer is shared by software strobes and received words
  // received words win over a software write to the same entry
  logic [7:0] buf_reg [WORDS]; // word buffer
  logic [7:0] sh_reg; // shift register
  logic [2:0] bit_reg; // bit counter
  logic [2:0] ptr_reg; // current entry
  logic [12:0] div_reg; // half period counter
  logic sck_reg; // internal clock level
  logic s1_reg; // external clock sync, first stage
  logic s2_reg; // external clock sync, second stage
  logic s3_reg; // previous synchronised level
  logic out_reg; // serial data out
  logic irq_reg; // interrupt pulse
  logic sw_touch_reg; // software accessed since done
  logic stop_reg; // end after current word
  logic dropped_reg; // external receive overrun
  // combinational decode and edge strobes, plus the unread flag register
  logic [12:0] half; // selected half period
  logic ext; // external clock chosen
  logic is_tx; // mode transmits
  logic is_rx; // mode receives
  logic is4; // 4-bit words
  logic mode_ok; // mode code not reserved
  logic unread_reg; // received block not yet read
  logic overrun; // external receive would overwrite
  logic fall; // leading edge strobe
  logic rise; // trailing edge strobe
  logic [2:0] top_bit; // last bit index
  logic word_end; // rising edge of last bit
  logic last_word; // pointer at programmed count

  // mode and clock decode
  // purely combinational from the control fields, which software
  // changes only while stopped or in a wait
  // the 4-bit flag picks the last bit index of every word
  // the pointer compare marks the final programmed word
  assign ext = ctrl.clock_source_select == CLK_EXTERNAL;
  assign is4 = ctrl.transfer_mode_select == MODE_TX4 ||
               ctrl.transfer_mode_select == MODE_RX4;
  assign is_tx = ctrl.transfer_mode_select == MODE_TX8 ||
                 ctrl.transfer_mode_select == MODE_TX4 ||
                 ctrl.transfer_mode_select == MODE_TXRX8;
  assign is_rx = ctrl.transfer_mode_select == MODE_RX8 ||
                 ctrl.transfer_mode_select == MODE_RX4 ||
                 ctrl.transfer_mode_select == MODE_TXRX8;
  assign top_bit = is4 ? 3'h3 : 3'h7;
  assign last_word = ptr_reg == ctrl.word_count_select;
  // reserved mode codes never start a transfer
  assign mode_ok = is_tx || is_rx;
  // with the external clock, a finished block still unread blocks the next store
  assign overrun = ext && is_rx && unread_reg;

  // half period per rate code, faster as code rises, except code 000 with the low-rate clock
  // codes 010 to 101 each halve the period of the one below it
  // 110 never starts, so its entry is a don't-care
  always_comb begin
    case (ctrl.clock_source_select)
      3'h0: half = ctrl.low_rate_divider_select ? HALF_LOW_RATE : HALF_SLOW;
      3'h1: half = HALF_R1;
      3'h2: half = HALF_R2;
      3'h3: half = HALF_R3;
      3'h4: half = HALF_R4;
      3'h5: half = HALF_R5;
      default: half = 13'h0007;
    endcase
  end

  // external clock synchroniser
  // two flops against metastability, the third keeps the previous
  // level so that both edges can be seen
  // reset high, the idle level of the pin, so no false edge follows
  // only the second stage reads the first
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= serial_clock_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // internal clock divider, runs only while shifting
  // parked high outside shifting, so the pin starts each frame high
  // and stays high through a wait; the external source bypasses it
  // a full period is two half periods of half plus one cycles
  // the counter restarts from zero at every start and wait release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 13'h0000;
      sck_reg <= 1'b1;
    end else if (state_reg != ST_SHIFT || ext) begin
      div_reg <= 13'h0000;
      sck_reg <= 1'b1;
    end else if (div_reg == half) begin
      div_reg <= 13'h0000;
      sck_reg <= ~sck_reg;
    end else begin
      div_reg <= div_reg + 13'h0001;
    end
  end

  // edge detect on chosen clock
  // internal edges fire on the cycle the divider flips the level,
  // so data moves together with the pin
  // external edges arrive two cycles after the pin moves, well
  // inside the minimum pulse width asked of the clock master
  always_comb begin
    if (ext) begin
      fall = s3_reg & ~s2_reg;
      rise = ~s3_reg & s2_reg;
    end else begin
      fall = sck_reg && div_reg == half;
      rise = !sck_reg && div_reg == half;
    end
    word_end = rise && bit_reg == top_bit;
  end

  // software touch tracking for wait release
  // any write, or a read in receive modes, counts, even outside
  // the programmed words: that is how the wait is released
  // cleared when a block ends so the next block starts fresh
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sw_touch_reg <= 1'b0;
    end else if (acc.wr || (acc.rd && is_rx)) begin
      sw_touch_reg <= 1'b1;
    end else if (state_reg == ST_SHIFT && word_end && last_word) begin
      sw_touch_reg <= 1'b0;
    end
  end

  // transfer sequencer
  // counts bits per word and words per block, raises the done
  // pulse after the last word and decides how the block ends
  // abort has priority in every busy state
  // a cleared run request is latched so that the word in flight
  // still completes before the sequencer parks
  // the done pulse is a register and stands exactly one cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      bit_reg <= 3'h0;
      ptr_reg <= 3'h0;
      stop_reg <= 1'b0;
      dropped_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          bit_reg <= 3'h0;
          ptr_reg <= 3'h0;
          stop_reg <= 1'b0;
          dropped_reg <= 1'b0;
          // start only on a legal mode and rate
          if (ctrl.run_request && !ctrl.abort_request && mode_ok &&
              ctrl.clock_source_select != CLK_RESERVED) begin
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (ctrl.abort_request) begin
            state_reg <= ST_IDLE;
          end else begin
            if (!ctrl.run_request) begin
              stop_reg <= 1'b1;
            end
            if (word_end) begin
              bit_reg <= 3'h0;
              // unread block: drop this word and give up
              if (overrun) begin
                dropped_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end else if (last_word) begin
                irq_reg <= 1'b1;
                ptr_reg <= 3'h0;
                // block done: end, wait for software, send filler, or go straight on to the next block
                if (stop_reg || !ctrl.run_request || dropped_reg) begin
                  state_reg <= ST_IDLE;
                end else if (!ext && !sw_touch_reg &&
                             !(acc.wr || (acc.rd && is_rx))) begin
                  state_reg <= ST_WAIT;
                end else if (ext && is_tx && !sw_touch_reg) begin
                  state_reg <= ST_LAST;
                end
              end else begin
                ptr_reg <= ptr_reg + 3'h1;
                if (stop_reg || !ctrl.run_request) begin
                  state_reg <= ST_IDLE;
                end
              end
            end else if (rise) begin
              bit_reg <= bit_reg + 3'h1;
            end
          end
        end
        ST_WAIT: begin
          // clock parked high until software catches up
          if (ctrl.abort_request || !ctrl.run_request) begin
            state_reg <= ST_IDLE;
          end else if (acc.wr || (acc.rd && is_rx)) begin
            state_reg <= ST_SHIFT;
          end
        end
        ST_LAST: begin
          // one filler word, then the transfer ends
          if (ctrl.abort_request) begin
            state_reg <= ST_IDLE;
          end else if (word_end) begin
            state_reg <= ST_IDLE;
          end else if (rise) begin
            bit_reg <= bit_reg + 3'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // external overrun: unread word blocks storage
  // set when a received block completes, cleared by any read
  // the set wins when both fall in one cycle, so a fresh block is
  // never taken as read by a read of the old one
  // only the external clock acts on it; the internal clock waits
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      unread_reg <= 1'b0;
    end else if (state_reg == ST_SHIFT && word_end && is_rx && last_word) begin
      unread_reg <= 1'b1;
    end else if (acc.rd) begin
      unread_reg <= 1'b0;
    end
  end

  // shift register: transmit on fall, receive on rise
  // preloaded from entry zero while idle so the first bit is ready
  // in transmit-receive the same register serves both directions:
  // a bit is sent on the fall before its place is refilled on the rise
  // transmit-only reloads the next entry right after the last bit
  // in external transmit the filler word goes out once when no new data came in time
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sh_reg <= WORD_RESET;
      out_reg <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      sh_reg <= buf_reg[0];
      out_reg <= 1'b1;
    end else if (state_reg == ST_LAST && fall && bit_reg == 3'h0) begin
      sh_reg <= FILLER_WORD;
      out_reg <= FILLER_WORD[0];
    end else if (fall && is_tx) begin
      out_reg <= sh_reg[bit_reg];
    end else if (rise && is_rx) begin
      sh_reg[bit_reg] <= serial_in_pin;
    end else if (state_reg == ST_SHIFT && word_end && is_tx && !is_rx) begin
      sh_reg <= buf_reg[last_word ? 3'h0 : ptr_reg + 3'h1];
    end
  end

  // buffer storage, software and receive writes
  // one flop word per entry, addressed by index
  // a received word is built from the shift register plus the bit
  // that arrives on the final rising edge
  // 4-bit words get a zero upper nibble
  // an overrun keeps the unread block intact
  generate
    for (genvar i = 0; i < WORDS; i++) begin : g_buf
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          buf_reg[i] <= WORD_RESET;
        end else if (state_reg == ST_SHIFT && word_end && is_rx &&
                     !overrun && ptr_reg == 3'(i)) begin
          buf_reg[i] <= is4 ? {4'h0, serial_in_pin, sh_reg[2:0]} :
                              {serial_in_pin, sh_reg[6:0]};
        end else if (acc.wr && acc.idx == 3'(i)) begin
          buf_reg[i] <= acc.wdata;
        end
      end
    end
  endgenerate

  // registered read port, data one cycle after the strobe
  // holds its value between reads
  // reads never disturb the entry they look at
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= WORD_RESET;
    end else if (acc.rd) begin
      rdata <= buf_reg[acc.idx];
    end
  end

  // pin and status outputs
  // the clock pin is driven only while the internal source is chosen
  // the active flag covers waits as well as shifting
  assign transfer_active_flag = state_reg != ST_IDLE;
  assign shift_active = state_reg == ST_SHIFT || state_reg == ST_LAST;
  assign serial_done_irq = irq_reg;
  // forced high in idle so an abort in a low phase parks it at once
  assign serial_clock_out = sck_reg || state_reg == ST_IDLE;
  assign serial_clock_oe = !ext;
  assign serial_out_pin = out_reg;
endmodule

/* File: test/serial_port_assertions.sv */
module serial_port_assertions (
  input wire logic mclk, // clock
  input wire logic resetn, // reset
  input wire serial_port_pkg::ctrl_t ctrl, // control
  input wire serial_port_pkg::buf_access_t acc, // access
  input wire logic [7:0] rdata, // read data
  input wire logic transfer_active_flag, // active
  input wire logic shift_active, // shifting
  input wire logic serial_done_irq, // done pulse
  input wire logic serial_clock_in, // clock in
  input wire logic serial_clock_out, // clock out
  input wire logic serial_clock_oe, // clock enable
  input wire logic serial_out_pin, // data out
  input wire logic serial_in_pin // data in
);
  timeunit 1ns;
  timeprecision 1ps;
  import serial_port_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // pin driven unless the external source is chosen
  clk_drive_a: assert property ($stable(ctrl.clock_source_select) |->
    serial_clock_oe == (ctrl.clock_source_select != CLK_EXTERNAL)) else $error("clock oe wrong");
  idle_high_a: assert property (!transfer_active_flag && serial_clock_oe |-> serial_clock_out)
    else $error("clock not high when idle");
  // data moves only while the clock is low
  tx_edge_a: assert property (shift_active && serial_clock_oe && $changed(serial_out_pin)
    |-> !serial_clock_out) else $error("data changed off falling edge");
  irq_pulse_a: assert property (serial_done_irq |=> !serial_done_irq)
    else $error("done pulse too long");
  irq_cause_a: assert property (serial_done_irq |-> $past(transfer_active_flag))
    else $error("done without transfer");
  abort_stop_a: assert property (ctrl.abort_request |=> !transfer_active_flag)
    else $error("abort did not stop");
  bad_rate_a: assert property (!transfer_active_flag
    && ctrl.clock_source_select == CLK_RESERVED |=> !transfer_active_flag) else $error("rate");
  bad_mode_a: assert property (!transfer_active_flag
    && ctrl.transfer_mode_select inside {3'h1, 3'h3, 3'h7} |=> !transfer_active_flag)
    else $error("reserved mode started");
  shift_flag_a: assert property (shift_active |-> transfer_active_flag)
    else $error("shifting while inactive");
endmodule
bind buffered_clocked_serial_port serial_port_assertions u_chk (.mclk, .resetn, .ctrl, .acc,
  .rdata, .transfer_active_flag, .shift_active, .serial_done_irq, .serial_clock_in,
  .serial_clock_out, .serial_clock_oe, .serial_out_pin, .serial_in_pin);

/* File: test/serial_peer_model.sv */
module serial_peer_model (
  input wire logic mclk, // clock
  input wire logic start, // frame start
  input wire logic sck, // clock pin level
  input wire logic sdo, // device data out
  input wire logic [7:0] send, // word to send
  output logic sdi, // data to device
  output logic [7:0] got // bits taken in
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0; // next bit to send
  initial sdi = 1'b1;
  initial got = 8'h00;
  // rewind per frame, leave no stale level
  always @(posedge mclk) begin
    if (start) begin
      idx <= 0;
      sdi <= ~sdi;
    end
  end
  // launch on falling edge, lsb first
  always @(negedge sck) begin
    sdi <= send[idx[2:0]];
    idx <= idx + 1;
  end
  // take on rising edge, lsb ends lowest
  always @(posedge sck) got <= {sdo, got[7:1]};
endmodule

/* File: test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_port_pkg::*;
  logic mclk = 1'b0; // system clock
  logic resetn = 1'b0; // reset, active low
  ctrl_t ctrl = '0; // control fields
  buf_access_t acc = '0; // buffer access
  logic sck_x = 1'b1; // external clock, idles high
  logic start = 1'b0; // peer frame start
  logic [7:0] send = 8'h00; // peer word
  logic [7:0] rdata, got; // read data, peer capture
  logic flag, shift, irq, sck_o, sck_oe, so, si; // design pins
  logic [31:0] seed = 32'h0000520e; // xorshift state
  int n_mismatch = 0;
  int n_checks = 0;
  logic [2:0] modes [5] = '{MODE_TX8, MODE_TX4, MODE_TXRX8, MODE_RX8, MODE_RX4};
  wire logic sck = sck_oe ? sck_o : sck_x; // clock pin level
  always #4 mclk = ~mclk;
  buffered_clocked_serial_port u_buffered_clocked_serial_port (.mclk, .resetn, .ctrl, .acc,
    .rdata, .transfer_active_flag(flag), .shift_active(shift), .serial_done_irq(irq),
    .serial_clock_in(sck), .serial_clock_out(sck_o), .serial_clock_oe(sck_oe),
    .serial_out_pin(so), .serial_in_pin(si));
  serial_peer_model u_serial_peer_model (.mclk, .start, .sck, .sdo(so), .send, .sdi(si), .got);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // 4-bit modes keep the low nibble only
  function automatic logic [7:0] exp_word(input logic [2:0] m, input logic [7:0] d);
    return (m == MODE_TX4 || m == MODE_RX4) ? {4'h0, d[3:0]} : d;
  endfunction
  task automatic cyc();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    n_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task test_done();
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for done pulse or end; drives the external clock while waiting for the pulse
  task automatic wait_for(input logic want_irq);
    int i;
    for (i = 0; i < 40000; i++) begin
      if (ctrl.clock_source_select == CLK_EXTERNAL && want_irq)
        sck_x = ((i / 5) % 2 == 0);
      cyc();
      if (want_irq ? irq : !flag) break;
    end
    sck_x = 1'b1;
    if (i == 40000) begin
      n_mismatch++;
      test_done();
    end
  endtask
  // one word: load, run, stop, compare the receiving end, both ends in transmit-receive
  task automatic xfer(input logic [2:0] m, input logic [2:0] s, input logic [7:0] d);
    cyc();
    ctrl.transfer_mode_select = m;
    ctrl.clock_source_select = s;
    send = d;
    start = 1'b1;
    cyc();
    start = 1'b0;
    acc = '{wr: 1'b1, rd: 1'b0, idx: 3'h0, wdata: d};
    cyc();
    acc.wr = 1'b0;
    ctrl.run_request = 1'b1;
    repeat (2) cyc();
    ctrl.run_request = 1'b0;
    wait_for(1'b1);
    wait_for(1'b0);
    if (m inside {MODE_TX8, MODE_TX4, MODE_TXRX8})
      chk(m == MODE_TX4 ? {4'h0, got[7:4]} : got, exp_word(m, d));
    if (m inside {MODE_TXRX8, MODE_RX8, MODE_RX4}) begin
      acc = '{wr: 1'b0, rd: 1'b1, idx: 3'h0, wdata: 8'h00};
      cyc();
      acc.rd = 1'b0;
      cyc();
      chk(rdata, exp_word(m, d));
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    chk({4'h0, flag, irq, sck_o, so}, 8'h03);
    ctrl.low_rate_divider_select = 1'b1;
    ctrl.word_count_select = 3'h0;
    for (int i = 0; i < 5; i++) xfer(modes[i], 3'h5, 8'(rnd()));
    for (int i = 0; i < 5; i++) xfer(modes[i], CLK_EXTERNAL, 8'(rnd()));
    repeat (6) xfer(modes[rnd() % 5], 3'(rnd() % 6), 8'(rnd()));
    for (int i = 0; i < 2; i++) begin
      ctrl.clock_source_select = i ? 3'h5 : CLK_RESERVED;
      ctrl.transfer_mode_select = i ? 3'h3 : MODE_TX8;
      ctrl.run_request = 1'b1;
      repeat (3) cyc();
      chk({7'h0, flag}, 8'h00);
      ctrl.run_request = 1'b0;
    end
    ctrl.transfer_mode_select = MODE_TX8;
    ctrl.clock_source_select = 3'h1;
    ctrl.run_request = 1'b1;
    repeat (40) cyc();
    chk({7'h0, flag}, 8'h01);
    ctrl.abort_request = 1'b1;
    cyc();
    ctrl.abort_request = 1'b0;
    ctrl.run_request = 1'b0;
    chk({7'h0, flag}, 8'h00);
    test_done();
  end
endmodule
